// >>> logic/ecu_regs.svh
// Purpose: register offsets, field positions, reset values and cycle counts of the execution core
// Assumes: included by the core only; the package does not include it
// Notes:   definitions only
`ifndef ECU_REGS_SVH
`define ECU_REGS_SVH

// apb byte offsets
`define ECU_OFF_INSTR    8'h00
`define ECU_OFF_STATUS   8'h04
`define ECU_OFF_PC       8'h08
`define ECU_OFF_RSEL     8'h0c
`define ECU_OFF_RDATA    8'h10

// status word layout
`define ECU_ST_BUSY      8
`define ECU_ST_CYC       16

// flag bit positions in the status flags register
`define ECU_F_C          0
`define ECU_F_Z          1
`define ECU_F_N          2
`define ECU_F_V          3
`define ECU_F_S          4
`define ECU_F_H          5
`define ECU_F_T          6
`define ECU_F_I          7

// storage sizes and fixed register indices
`define ECU_NREG         32
`define ECU_NDM          64
`define ECU_NIO          32
`define ECU_R0           5'h00
`define ECU_R1           5'h01
`define ECU_XL           5'h1a
`define ECU_ZL           5'h1e
`define ECU_ZH           5'h1f

// reset values
`define ECU_RF_RESET     8'h00
`define ECU_STATUS_FLAGS_REGISTER_RESET   8'h00
`define ECU_PC_RESET     16'h0000
`define ECU_SP_RESET     6'h3f

// cycle counts and steps
`define ECU_CYC_ONE      2'h1
`define ECU_CYC_TWO      2'h2
`define ECU_CYC_THREE    2'h3
`define ECU_PC_STEP      16'h0001
`define ECU_PC_SKIP2     16'h0002
`define ECU_PC_SKIP3     16'h0003
`define ECU_SP_STEP      6'h01
`define ECU_SP_CALL      6'h02
`define ECU_ALL_ONES     8'hff
`define ECU_MODE_POSTINC 2'h1
`define ECU_MODE_PREDEC  2'h2

`endif

// >>> logic/ecu_pkg.sv
// Purpose: types of the execution core
// Assumes: nothing
// Notes:   instruction word layout is the ecu_instr_s struct
`default_nettype none
package ecu_pkg;

  typedef enum logic [5:0] {
    op_nop        = 6'h00, op_add        = 6'h01, op_add_carry  = 6'h02, op_sub       = 6'h03,
    op_sub_const  = 6'h04, op_sub_carry  = 6'h05, op_sub_cc     = 6'h06, op_and       = 6'h07,
    op_and_const  = 6'h08, op_or         = 6'h09, op_or_const   = 6'h0a, op_xor       = 6'h0b,
    op_clear_bits = 6'h0c, op_test       = 6'h0d, op_add_word   = 6'h0e, op_sub_word  = 6'h0f,
    op_mul_uu     = 6'h10, op_mul_ss     = 6'h11, op_mul_su     = 6'h12, op_fmul_uu   = 6'h13,
    op_fmul_ss    = 6'h14, op_fmul_su    = 6'h15, op_ijump      = 6'h16, op_indirect_call     = 6'h17,
    op_skip_rclr  = 6'h18, op_skip_rset  = 6'h19, op_skip_ioclr = 6'h1a, op_skip_ioset = 6'h1b,
    op_cmp        = 6'h1c, op_cmp_carry  = 6'h1d, op_cmp_const  = 6'h1e, op_br_set    = 6'h1f,
    op_br_clr     = 6'h20, op_br_ge      = 6'h21, op_br_lt      = 6'h22, op_load      = 6'h23,
    op_store      = 6'h24, op_load_disp  = 6'h25, op_store_disp = 6'h26, op_load_prog = 6'h27,
    op_push       = 6'h28, op_pop        = 6'h29, op_io_set     = 6'h2a, op_io_clr    = 6'h2b,
    op_shl        = 6'h2c, op_shr        = 6'h2d, op_rol        = 6'h2e, op_ror       = 6'h2f,
    op_asr        = 6'h30, op_bit_to_t   = 6'h31, op_t_to_bit   = 6'h32, op_flag_set  = 6'h33,
    op_flag_clr   = 6'h34, op_sleep      = 6'h35, op_wdog       = 6'h36
  } ecu_op_e;

  // instruction word as written to the instruction register
  typedef struct packed {
    logic [3:0] pad;       // reads back, unused
    logic       two_word;  // following instruction is two words long
    logic [2:0] bitsel;    // bit index, flag index or pointer select
    logic [7:0] imm;       // constant, offset, displacement or addressing mode
    logic [4:0] rr;        // source register or io location
    logic [4:0] rd;        // destination register
    ecu_op_e    op;        // operation
  } ecu_instr_s;

endpackage : ecu_pkg
`default_nettype wire

// >>> logic/ecu_core.sv
// Purpose: 8-bit instruction execution core with apb access
// Assumes: program memory answers pm_rdata in the same cycle as pm_addr
// Notes:   one instruction at a time; busy covers its whole cycle count
`include "ecu_regs.svh"
`default_nettype none

// Behaviour
// - add stores sum, five flags, one cycle
// - word add/sub on pair, two cycles
// - subtract register/constant, five flags, one cycle
// - and/or/xor touch Z N V only
// - clear bits ands with inverted constant
// - test ands register with itself
// - multiplies into r1:r0, Z C, two cycles
// - indirect jump 2, call 3 cycles
// - bit skips advance pc by 2 or 3
// - compare sets flags, stores nothing
// - branch to pc+k+1, one/two cycles
// - signed branches test N xor V
// - pointer loads/stores, predec and postinc
// - displacement access leaves pointer unchanged
// - program memory load, three cycles
// - push and pop, two cycles
// - io bit set/clear, two cycles
// - shifts and rotates, carry chain, one cycle
// - bit to transfer flag and back
// - per flag set and clear
// - nop, sleep, watchdog restart one cycle
module ecu_core (
  input  wire logic        mclk,        // core clock
  input  wire logic        rst,         // synchronous reset, high
  input  wire logic        psel,        // apb select
  input  wire logic        penable,     // apb enable
  input  wire logic        pwrite,      // apb direction
  input  wire logic [7:0]  paddr,       // apb byte address
  input  wire logic [31:0] pwdata,      // apb write data
  output logic      [31:0] prdata,      // apb read data
  output logic             pready,      // apb ready
  output logic             pslverr,     // apb error on unmapped address
  output logic      [15:0] pm_addr,     // program memory byte address
  input  wire logic [7:0]  pm_rdata,    // program memory byte
  output logic             sleep_req,   // sleep request pulse
  output logic             wdt_restart  // watchdog restart pulse
);

  logic [7:0]  rf [`ECU_NREG];
  logic [7:0]  dm [`ECU_NDM];
  logic [7:0]  io [`ECU_NIO];
  logic [7:0]  status_flags_register;
  logic [15:0] pc;
  logic [5:0]  sp;
  logic [4:0]  rsel;
  logic [1:0]  wait_cnt;
  logic [1:0]  last_cyc;
  logic        exec;
  ecu_pkg::ecu_instr_s ir;

  logic        busy, acc, setup, mapped, start, apb_we;
  logic [31:0] status_word;
  logic [7:0]  a, b, r8, wa_val, dm_wd, dm_wd2, io_wd, next_status_flags_register;
  logic [8:0]  s9;
  logic [15:0] pv, wv, ea, r16, ax, bx, prod, zptr, kext, ret, wb_val, next_pc;
  logic [4:0]  pb, wa, wb, io_a;
  logic [5:0]  dm_a, next_sp;
  logic [1:0]  cyc;
  logic        cin, cnd, c1, wa_en, wb_en, dm_we, dm_w2, io_we, slp, wdg;

  // apb decode
  assign setup  = psel & ~penable;
  assign acc    = psel & penable;
  assign pready = 1'b1;
  assign mapped = (paddr == `ECU_OFF_INSTR) || (paddr == `ECU_OFF_STATUS) ||
                  (paddr == `ECU_OFF_PC) || (paddr == `ECU_OFF_RSEL) ||
                  (paddr == `ECU_OFF_RDATA);
  assign pslverr = acc & ~mapped;
  assign apb_we  = acc & pwrite & ~busy;
  assign busy    = exec | (wait_cnt != 2'h0);
  assign start   = apb_we & (paddr == `ECU_OFF_INSTR);

  // status word seen by software
  always_comb begin
    status_word = '0;
    status_word[7:0] = status_flags_register;
    status_word[`ECU_ST_BUSY] = busy;
    status_word[`ECU_ST_CYC +: 2] = last_cyc;
  end

  // read data captured in the setup cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      prdata <= '0;
    end else if (setup) begin
      if (paddr == `ECU_OFF_INSTR) begin
        prdata <= ir;
      end else if (paddr == `ECU_OFF_STATUS) begin
        prdata <= status_word;
      end else if (paddr == `ECU_OFF_PC) begin
        prdata <= {16'h0000, pc};
      end else if (paddr == `ECU_OFF_RSEL) begin
        prdata <= {27'h0000000, rsel};
      end else if (paddr == `ECU_OFF_RDATA) begin
        prdata <= {24'h000000, rf[rsel]};
      end else begin
        prdata <= '0;
      end
    end
  end

  // instruction latch and cycle accounting
  always_ff @(posedge mclk) begin
    if (rst) begin
      exec     <= 1'b0;
      ir       <= '0;
      wait_cnt <= 2'h0;
      last_cyc <= 2'h0;
    end else begin
      exec <= start;
      if (start) begin
        ir <= pwdata;
      end
      if (exec) begin
        wait_cnt <= 2'(cyc - `ECU_CYC_ONE);
        last_cyc <= cyc;
      end else if (wait_cnt != 2'h0) begin
        wait_cnt <= 2'(wait_cnt - 2'h1);
      end
    end
  end

  // operand fetch
  assign zptr    = {rf[`ECU_ZH], rf[`ECU_ZL]};
  assign pm_addr = zptr;
  assign pb      = `ECU_XL + {2'b00, ir.bitsel[1:0], 1'b0};
  assign pv      = {rf[pb | 5'h01], rf[pb]};
  assign wv      = {rf[{ir.rd[4:1], 1'b1}], rf[{ir.rd[4:1], 1'b0}]};
  assign kext    = {{8{ir.imm[7]}}, ir.imm};
  assign ret     = pc + `ECU_PC_STEP;

  // execution datapath
  always_comb begin
    a = rf[ir.rd];
    b = rf[ir.rr];
    cin = 1'b0; cnd = 1'b0; c1 = 1'b0;
    s9 = '0; r8 = '0; r16 = '0; ax = '0; bx = '0; prod = '0;
    wa_en = 1'b0; wa = ir.rd; wa_val = a;
    wb_en = 1'b0; wb = pb; wb_val = pv;
    ea = pv;
    dm_we = 1'b0; dm_w2 = 1'b0; dm_a = sp; dm_wd = a; dm_wd2 = ret[15:8];
    io_we = 1'b0; io_a = ir.rr; io_wd = io[ir.rr];
    next_status_flags_register = status_flags_register; next_pc = ret; next_sp = sp; cyc = `ECU_CYC_ONE;
    slp = 1'b0; wdg = 1'b0;
    case (ir.op)
      ecu_pkg::op_add, ecu_pkg::op_add_carry: begin
        cin = (ir.op == ecu_pkg::op_add_carry) & status_flags_register[`ECU_F_C];
        s9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        r8 = s9[7:0];
        next_status_flags_register[`ECU_F_C] = s9[8];
        next_status_flags_register[`ECU_F_H] = (a[3] & b[3]) | (b[3] & ~r8[3]) | (~r8[3] & a[3]);
        next_status_flags_register[`ECU_F_V] = (a[7] & b[7] & ~r8[7]) | (~a[7] & ~b[7] & r8[7]);
        next_status_flags_register[`ECU_F_N] = r8[7];
        next_status_flags_register[`ECU_F_Z] = ~|r8;
        wa_en = 1'b1; wa_val = r8;
      end
      ecu_pkg::op_sub, ecu_pkg::op_sub_const, ecu_pkg::op_sub_carry, ecu_pkg::op_sub_cc,
      ecu_pkg::op_cmp, ecu_pkg::op_cmp_carry, ecu_pkg::op_cmp_const: begin
        if (ir.op == ecu_pkg::op_sub_const || ir.op == ecu_pkg::op_sub_cc ||
            ir.op == ecu_pkg::op_cmp_const) begin
          b = ir.imm;
        end
        cin = (ir.op == ecu_pkg::op_sub_carry || ir.op == ecu_pkg::op_sub_cc ||
               ir.op == ecu_pkg::op_cmp_carry) & status_flags_register[`ECU_F_C];
        s9 = {1'b0, a} - {1'b0, b} - {8'h00, cin};
        r8 = s9[7:0];
        next_status_flags_register[`ECU_F_C] = s9[8];
        next_status_flags_register[`ECU_F_H] = (~a[3] & b[3]) | (b[3] & r8[3]) | (r8[3] & ~a[3]);
        next_status_flags_register[`ECU_F_V] = (a[7] & ~b[7] & ~r8[7]) | (~a[7] & b[7] & r8[7]);
        next_status_flags_register[`ECU_F_N] = r8[7];
        next_status_flags_register[`ECU_F_Z] = ~|r8;
        wa_en = (ir.op != ecu_pkg::op_cmp) && (ir.op != ecu_pkg::op_cmp_carry) &&
                (ir.op != ecu_pkg::op_cmp_const);
        wa_val = r8;
      end
      ecu_pkg::op_and, ecu_pkg::op_and_const, ecu_pkg::op_or, ecu_pkg::op_or_const,
      ecu_pkg::op_xor, ecu_pkg::op_clear_bits, ecu_pkg::op_test: begin
        if (ir.op == ecu_pkg::op_and) begin
          r8 = a & b;
        end else if (ir.op == ecu_pkg::op_and_const) begin
          r8 = a & ir.imm;
        end else if (ir.op == ecu_pkg::op_or) begin
          r8 = a | b;
        end else if (ir.op == ecu_pkg::op_or_const) begin
          r8 = a | ir.imm;
        end else if (ir.op == ecu_pkg::op_xor) begin
          r8 = a ^ b;
        end else if (ir.op == ecu_pkg::op_clear_bits) begin
          r8 = a & (`ECU_ALL_ONES - ir.imm);
        end else begin
          r8 = a & a;
        end
        next_status_flags_register[`ECU_F_V] = 1'b0;
        next_status_flags_register[`ECU_F_N] = r8[7];
        next_status_flags_register[`ECU_F_Z] = ~|r8;
        wa_en = 1'b1; wa_val = r8;
      end
      ecu_pkg::op_add_word, ecu_pkg::op_sub_word: begin
        if (ir.op == ecu_pkg::op_add_word) begin
          r16 = wv + {10'h000, ir.imm[5:0]};
          next_status_flags_register[`ECU_F_V] = ~wv[15] & r16[15];
          next_status_flags_register[`ECU_F_C] = wv[15] & ~r16[15];
        end else begin
          r16 = wv - {10'h000, ir.imm[5:0]};
          next_status_flags_register[`ECU_F_V] = wv[15] & ~r16[15];
          next_status_flags_register[`ECU_F_C] = ~wv[15] & r16[15];
        end
        next_status_flags_register[`ECU_F_N] = r16[15];
        next_status_flags_register[`ECU_F_S] = r16[15] ^ next_status_flags_register[`ECU_F_V];
        next_status_flags_register[`ECU_F_Z] = ~|r16;
        wb_en = 1'b1; wb = {ir.rd[4:1], 1'b0}; wb_val = r16;
        cyc = `ECU_CYC_TWO;
      end
      ecu_pkg::op_mul_uu, ecu_pkg::op_mul_ss, ecu_pkg::op_mul_su,
      ecu_pkg::op_fmul_uu, ecu_pkg::op_fmul_ss, ecu_pkg::op_fmul_su: begin
        ax = (ir.op == ecu_pkg::op_mul_uu || ir.op == ecu_pkg::op_fmul_uu) ?
             {8'h00, a} : {{8{a[7]}}, a};
        bx = (ir.op == ecu_pkg::op_mul_ss || ir.op == ecu_pkg::op_fmul_ss) ?
             {{8{b[7]}}, b} : {8'h00, b};
        prod = ax * bx;
        next_status_flags_register[`ECU_F_C] = prod[15];
        if (ir.op == ecu_pkg::op_fmul_uu || ir.op == ecu_pkg::op_fmul_ss ||
            ir.op == ecu_pkg::op_fmul_su) begin
          r16 = {prod[14:0], 1'b0};
        end else begin
          r16 = prod;
        end
        next_status_flags_register[`ECU_F_Z] = ~|r16;
        wb_en = 1'b1; wb = `ECU_R0; wb_val = r16;
        cyc = `ECU_CYC_TWO;
      end
      ecu_pkg::op_ijump: begin
        next_pc = zptr;
        cyc = `ECU_CYC_TWO;
      end
      ecu_pkg::op_indirect_call: begin
        next_pc = zptr;
        dm_we = 1'b1; dm_wd = ret[7:0];
        dm_w2 = 1'b1;
        next_sp = 6'(sp - `ECU_SP_CALL);
        cyc = `ECU_CYC_THREE;
      end
      ecu_pkg::op_skip_rclr, ecu_pkg::op_skip_rset, ecu_pkg::op_skip_ioclr,
      ecu_pkg::op_skip_ioset: begin
        if (ir.op == ecu_pkg::op_skip_rclr) begin
          cnd = ~a[ir.bitsel];
        end else if (ir.op == ecu_pkg::op_skip_rset) begin
          cnd = a[ir.bitsel];
        end else if (ir.op == ecu_pkg::op_skip_ioclr) begin
          cnd = ~io[ir.rr][ir.bitsel];
        end else begin
          cnd = io[ir.rr][ir.bitsel];
        end
        if (cnd) begin
          next_pc = pc + (ir.two_word ? `ECU_PC_SKIP3 : `ECU_PC_SKIP2);
          cyc = ir.two_word ? `ECU_CYC_THREE : `ECU_CYC_TWO;
        end
      end
      ecu_pkg::op_br_set, ecu_pkg::op_br_clr, ecu_pkg::op_br_ge, ecu_pkg::op_br_lt: begin
        if (ir.op == ecu_pkg::op_br_set) begin
          cnd = status_flags_register[ir.bitsel];
        end else if (ir.op == ecu_pkg::op_br_clr) begin
          cnd = ~status_flags_register[ir.bitsel];
        end else if (ir.op == ecu_pkg::op_br_ge) begin
          cnd = ~(status_flags_register[`ECU_F_N] ^ status_flags_register[`ECU_F_V]);
        end else begin
          cnd = status_flags_register[`ECU_F_N] ^ status_flags_register[`ECU_F_V];
        end
        if (cnd) begin
          next_pc = pc + kext + `ECU_PC_STEP;
          cyc = `ECU_CYC_TWO;
        end
      end
      ecu_pkg::op_load, ecu_pkg::op_store: begin
        if (ir.imm[1:0] == `ECU_MODE_PREDEC) begin
          ea = pv - `ECU_PC_STEP;
          wb_en = 1'b1; wb_val = ea;
        end else if (ir.imm[1:0] == `ECU_MODE_POSTINC) begin
          wb_en = 1'b1; wb_val = pv + `ECU_PC_STEP;
        end
        wa_en = (ir.op == ecu_pkg::op_load);
        wa_val = dm[ea[5:0]];
        dm_we = (ir.op == ecu_pkg::op_store); dm_a = ea[5:0];
        cyc = `ECU_CYC_TWO;
      end
      ecu_pkg::op_load_disp, ecu_pkg::op_store_disp: begin
        ea = pv + {10'h000, ir.imm[5:0]};
        wa_en = (ir.op == ecu_pkg::op_load_disp);
        wa_val = dm[ea[5:0]];
        dm_we = (ir.op == ecu_pkg::op_store_disp); dm_a = ea[5:0];
        cyc = `ECU_CYC_TWO;
      end
      ecu_pkg::op_load_prog: begin
        wa_en = 1'b1; wa_val = pm_rdata;
        wb_en = ir.imm[0]; wb = `ECU_ZL; wb_val = zptr + `ECU_PC_STEP;
        cyc = `ECU_CYC_THREE;
      end
      ecu_pkg::op_push: begin
        dm_we = 1'b1;
        next_sp = 6'(sp - `ECU_SP_STEP);
        cyc = `ECU_CYC_TWO;
      end
      ecu_pkg::op_pop: begin
        next_sp = 6'(sp + `ECU_SP_STEP);
        wa_en = 1'b1; wa_val = dm[next_sp];
        cyc = `ECU_CYC_TWO;
      end
      ecu_pkg::op_io_set, ecu_pkg::op_io_clr: begin
        io_we = 1'b1;
        io_wd[ir.bitsel] = (ir.op == ecu_pkg::op_io_set);
        cyc = `ECU_CYC_TWO;
      end
      ecu_pkg::op_shl, ecu_pkg::op_shr, ecu_pkg::op_rol, ecu_pkg::op_ror, ecu_pkg::op_asr: begin
        if (ir.op == ecu_pkg::op_shl) begin
          r8 = {a[6:0], 1'b0}; c1 = a[7];
        end else if (ir.op == ecu_pkg::op_rol) begin
          r8 = {a[6:0], status_flags_register[`ECU_F_C]}; c1 = a[7];
        end else if (ir.op == ecu_pkg::op_shr) begin
          r8 = {1'b0, a[7:1]}; c1 = a[0];
        end else if (ir.op == ecu_pkg::op_ror) begin
          r8 = {status_flags_register[`ECU_F_C], a[7:1]}; c1 = a[0];
        end else begin
          r8 = {a[7], a[7:1]}; c1 = a[0];
        end
        next_status_flags_register[`ECU_F_C] = c1;
        next_status_flags_register[`ECU_F_N] = r8[7];
        next_status_flags_register[`ECU_F_V] = r8[7] ^ c1;
        next_status_flags_register[`ECU_F_Z] = ~|r8;
        wa_en = 1'b1; wa_val = r8;
      end
      ecu_pkg::op_bit_to_t: begin
        next_status_flags_register[`ECU_F_T] = a[ir.bitsel];
      end
      ecu_pkg::op_t_to_bit: begin
        wa_en = 1'b1;
        wa_val[ir.bitsel] = status_flags_register[`ECU_F_T];
      end
      ecu_pkg::op_flag_set, ecu_pkg::op_flag_clr: begin
        next_status_flags_register[ir.bitsel] = (ir.op == ecu_pkg::op_flag_set);
      end
      ecu_pkg::op_sleep: slp = 1'b1;
      ecu_pkg::op_wdog:  wdg = 1'b1;
      default: ;
    endcase
  end

  // register file, one process per entry
  for (genvar g = 0; g < `ECU_NREG; g++) begin : g_rf
    always_ff @(posedge mclk) begin
      if (rst) begin
        rf[g] <= `ECU_RF_RESET;
      end else if (exec && wa_en && wa == 5'(g)) begin
        rf[g] <= wa_val;
      end else if (exec && wb_en && wb[4:1] == 4'(g / 2)) begin
        rf[g] <= wb_val[8 * (g % 2) +: 8];
      end else if (apb_we && paddr == `ECU_OFF_RDATA && rsel == 5'(g)) begin
        rf[g] <= pwdata[7:0];
      end
    end
  end

  // data memory and stack, return address low byte at sp, high below
  always_ff @(posedge mclk) begin
    if (exec && dm_we) begin
      dm[dm_a] <= dm_wd;
    end
    if (exec && dm_w2) begin
      dm[6'(dm_a - `ECU_SP_STEP)] <= dm_wd2;
    end
  end

  // io space
  always_ff @(posedge mclk) begin
    if (exec && io_we) begin
      io[io_a] <= io_wd;
    end
  end

  // program counter, flags, stack pointer, register select
  always_ff @(posedge mclk) begin
    if (rst) begin
      pc   <= `ECU_PC_RESET;
      status_flags_register <= `ECU_STATUS_FLAGS_REGISTER_RESET;
      sp   <= `ECU_SP_RESET;
      rsel <= 5'h00;
    end else begin
      if (exec) begin
        pc   <= next_pc;
        status_flags_register <= next_status_flags_register;
        sp   <= next_sp;
      end else if (apb_we && paddr == `ECU_OFF_PC) begin
        pc <= pwdata[15:0];
      end else if (apb_we && paddr == `ECU_OFF_STATUS) begin
        status_flags_register <= pwdata[7:0];
      end
      if (acc && pwrite && paddr == `ECU_OFF_RSEL) begin
        rsel <= pwdata[4:0];
      end
    end
  end

  // side-effect pulses for sleep and watchdog units
  always_ff @(posedge mclk) begin
    if (rst) begin
      sleep_req   <= 1'b0;
      wdt_restart <= 1'b0;
    end else begin
      sleep_req   <= exec & slp;
      wdt_restart <= exec & wdg;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence run_of(ecu_pkg::ecu_op_e o);
    exec && ir.op == o;
  endsequence
  sequence done_1;
    ##1 !busy;
  endsequence
  sequence done_2;
    ##1 busy ##1 !busy;
  endsequence
  sequence done_3;
    ##1 busy [*2] ##1 !busy;
  endsequence

  add_timing_a: assert property (run_of(ecu_pkg::op_add) |-> done_1)
    else $error("add did not finish in one cycle");
  word_timing_a: assert property (run_of(ecu_pkg::op_sub_word) |-> done_2)
    else $error("word subtract did not take two cycles");
  logic_flags_a: assert property (run_of(ecu_pkg::op_xor) |=>
    status_flags_register[`ECU_F_C] == $past(status_flags_register[`ECU_F_C]) && status_flags_register[`ECU_F_H] == $past(status_flags_register[`ECU_F_H])
    && !status_flags_register[`ECU_F_V])
    else $error("logic op disturbed carry or half carry");
  mul_product_a: assert property (run_of(ecu_pkg::op_mul_uu) |=>
    {rf[`ECU_R1], rf[`ECU_R0]} == 16'({8'h00, $past(a)} * {8'h00, $past(b)}))
    else $error("unsigned product wrong");
  call_timing_a: assert property (run_of(ecu_pkg::op_indirect_call) |=>
    pc == $past(zptr) ##0 busy ##1 busy ##1 !busy)
    else $error("indirect call target or timing wrong");
  skip_target_a: assert property (run_of(ecu_pkg::op_skip_rset) ##0 (a[ir.bitsel]
    && !ir.two_word) |=> pc == $past(pc) + `ECU_PC_SKIP2 ##0 busy ##1 !busy)
    else $error("skip target wrong");
  branch_idle_a: assert property (run_of(ecu_pkg::op_br_set) ##0 !status_flags_register[ir.bitsel] |=>
    pc == $past(pc) + `ECU_PC_STEP && !busy)
    else $error("untaken branch wrong");
  signed_branch_a: assert property (run_of(ecu_pkg::op_br_lt) ##0
    (status_flags_register[`ECU_F_N] ^ status_flags_register[`ECU_F_V]) |=> pc == $past(pc) + $past(kext) + `ECU_PC_STEP)
    else $error("signed less-than branch target wrong");
  postinc_ptr_a: assert property (run_of(ecu_pkg::op_load) ##0
    (ir.imm[1:0] == `ECU_MODE_POSTINC && ir.rd < `ECU_XL) |=>
    {rf[$past(pb) | 5'h01], rf[$past(pb)]} == $past(pv) + `ECU_PC_STEP)
    else $error("pointer post increment wrong");
  flag_only_a: assert property (run_of(ecu_pkg::op_flag_clr) |=>
    !status_flags_register[$past(ir.bitsel)] && (status_flags_register | (8'h01 << $past(ir.bitsel))) ==
    ($past(status_flags_register) | (8'h01 << $past(ir.bitsel))))
    else $error("flag clear touched other flags");

endmodule : ecu_core
`default_nettype wire

// >>> logic/ecu_dummy_unused.sv
// Purpose: holds no logic; the whole core sits in ecu_core
// Assumes: nothing
// Notes:   intentionally empty module-free file
`default_nettype none
`default_nettype wire

// >>> testbench/tb_top.sv
// Purpose: self-checking bench of the execution core over apb
// Assumes: core answers apb in its first access cycle; busy polled after each instruction
// Notes:   random operands from a fixed seed; alu expectations from the alu function, the others computed inline
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        pready, pslverr, ps, tk, sleep_req, wdt_restart;
  logic [7:0]  paddr = 8'h00, pm_rdata = 8'h00, a, b, f, k;
  logic [7:0]  pulses = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [15:0] e, z, pm_addr;
  logic [5:0]  ops [7] = '{6'h01, 6'h02, 6'h03, 6'h05, 6'h07, 6'h09, 6'h0b};
  int          miscompares = 0, checks = 0, i;

  ecu_core i_dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pm_addr(pm_addr), .pm_rdata(pm_rdata), .sleep_req(sleep_req), .wdt_restart(wdt_restart));

  // side-effect pulses: sleep counted in the low nibble, watchdog in the high
  always @(posedge mclk) begin
    if (!rst) pulses <= pulses + {3'h0, wdt_restart, 3'h0, sleep_req};
  end

  // core clock
  initial begin
    forever #20 mclk = ~mclk;
  end

  task automatic give_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      miscompares++;
      give_verdict();
    end
    q = prdata;
    ps = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic set_reg(input logic [4:0] r, input logic [7:0] v);
    apb(1'b1, 8'h0c, {27'h0, r});
    apb(1'b1, 8'h10, {24'h0, v});
  endtask

  task automatic get_reg(input logic [4:0] r);
    apb(1'b1, 8'h0c, {27'h0, r});
    apb(1'b0, 8'h10, 32'h0);
  endtask

  // issue an instruction, poll busy, compare the cycle count
  task automatic run(input logic [31:0] ins, input logic [1:0] cyc);
    int n;
    apb(1'b1, 8'h00, ins);
    n = 0;
    do begin
      apb(1'b0, 8'h04, 32'h0);
      n++;
    end while (q[8] !== 1'b0 && n < 16);
    if (q[8] !== 1'b0) begin
      miscompares++;
      give_verdict();
    end
    chk({30'h0, q[17:16]}, {30'h0, cyc});
  endtask

  // expected flags and result of register arithmetic and logic
  function automatic logic [15:0] alu(input logic [5:0] op, input logic [7:0] x, y, fl);
    logic [8:0] s;
    logic [7:0] o;
    logic       sb;
    o = fl;
    sb = op inside {6'h03, 6'h05};
    s = sb ? {1'b0, x} - {1'b0, y} - 9'((op == 6'h05) & fl[0])
           : {1'b0, x} + {1'b0, y} + 9'((op == 6'h02) & fl[0]);
    case (op)
      6'h07: s = {1'b0, x & y};
      6'h09: s = {1'b0, x | y};
      6'h0b: s = {1'b0, x ^ y};
      default: begin
        o[0] = s[8];
        o[5] = sb ? (~x[3] & y[3]) | (y[3] & s[3]) | (s[3] & ~x[3])
                  : (x[3] & y[3]) | (y[3] & ~s[3]) | (~s[3] & x[3]);
        o[3] = sb ? (x[7] & ~y[7] & ~s[7]) | (~x[7] & y[7] & s[7])
                  : (x[7] & y[7] & ~s[7]) | (~x[7] & ~y[7] & s[7]);
      end
    endcase
    if (op inside {6'h07, 6'h09, 6'h0b}) o[3] = 1'b0;
    o[1] = s[7:0] == 8'h00;
    o[2] = s[7];
    return {o, s[7:0]};
  endfunction

  // main sequence
  initial begin
    void'($urandom(10987));
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    for (i = 0; i < 28; i++) begin
      a = i < 7 ? 8'h80 : 8'($urandom);
      b = i < 7 ? 8'h80 : 8'($urandom);
      f = 8'($urandom);
      set_reg(5'd1, a);
      set_reg(5'd2, b);
      apb(1'b1, 8'h04, {24'h0, f});
      run({16'h0, 5'd2, 5'd1, ops[i % 7]}, 2'h1);
      e = alu(ops[i % 7], a, b, f);
      apb(1'b0, 8'h04, 32'h0);
      chk({24'h0, q[7:0]}, {24'h0, e[15:8]});
      get_reg(5'd1);
      chk(q, {24'h0, e[7:0]});
    end
    $display("test alu done");
    set_reg(5'd16, a);
    set_reg(5'd17, b);
    run({16'h0, 5'd17, 5'd16, 6'h10}, 2'h2);
    e = a * b;
    get_reg(5'd1);
    chk(q, {24'h0, e[15:8]});
    get_reg(5'd0);
    chk(q, {24'h0, e[7:0]});
    $display("test multiply done");
    z = 16'($urandom);
    set_reg(5'h1e, z[7:0]);
    set_reg(5'h1f, z[15:8]);
    run({26'h0, 6'h16}, 2'h2);
    apb(1'b0, 8'h08, 32'h0);
    chk(q, {16'h0, z});
    apb(1'b1, 8'h00, {26'h0, 6'h17});
    run({26'h0, 6'h00}, 2'h3); // nop refused while the call is busy
    apb(1'b0, 8'h08, 32'h0);
    chk(q, {16'h0, z});
    $display("test indirect done");
    for (i = 0; i < 8; i++) begin
      k = 8'($urandom_range(0, 127));
      tk = (i[0] ^ i[1]) == i[2];
      apb(1'b1, 8'h08, 32'h100);
      apb(1'b1, 8'h04, {28'h0, i[1:0], 2'h0});
      run({8'h0, k, 10'h0, 6'h21 + {5'h0, i[2]}}, tk ? 2'h2 : 2'h1);
      apb(1'b0, 8'h08, 32'h0);
      chk(q, 32'h101 + (tk ? {24'h0, k} : 32'h0));
    end
    $display("test branch done");
    apb(1'b1, 8'h04, 32'h0);
    set_reg(5'd24, 8'h05);
    set_reg(5'd25, 8'h00);
    run(32'h0006060f, 2'h2);
    get_reg(5'd25);
    chk(q, 32'hff);
    apb(1'b1, 8'h08, 32'h100);
    run(32'h03000619, 2'h2);
    run(32'h0140001f, 2'h1);
    apb(1'b0, 8'h08, 32'h0);
    chk(q, 32'h103);
    run(32'h02000034, 2'h1);
    apb(1'b0, 8'h04, 32'h0);
    chk({24'h0, q[7:0]}, 32'h11);
    $display("test word skip flag done");
    set_reg(5'd26, 8'h11);
    run(32'h00020624, 2'h2);
    run(32'h000100a3, 2'h2);
    get_reg(5'd2);
    chk(q, 32'hff);
    get_reg(5'd26);
    chk(q, 32'h11);
    k = 8'($urandom);
    pm_rdata <= k;
    run(32'h000100e7, 2'h3);
    get_reg(5'd3);
    chk(q, {24'h0, k});
    chk({16'h0, pm_addr}, {16'h0, z + 16'h1});
    run(32'h00000035, 2'h1);
    run(32'h00000036, 2'h1);
    chk({24'h0, pulses}, 32'h11);
    $display("test memory and control done");
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, ps}, 32'h1);
    $display("test unmapped done");
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
